// [design/pkt_pkg.sv]
// constants, types and helpers for the burst radio mode and packet control
package pkt_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ       = 100_000_000;
  localparam int BIT_RATE_BPS = 50_000;
  localparam int BIT_CYC      = CLK_HZ / BIT_RATE_BPS;
  localparam int SETTLE_US    = 650;
  localparam int SETTLE_CYC   = SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int SETTLE_W     = 17;
  localparam int DIV_W        = 11;

  // ************************************************************
  // packet layout
  // ************************************************************
  localparam int ADDR_W = 32;
  localparam int PAY_W  = 32;
  localparam int CRC_W  = 16;
  localparam int PRE_W  = 10;
  localparam int PKT_W  = PRE_W + ADDR_W + PAY_W + CRC_W;
  localparam int IDX_W  = 7;
  localparam logic [PRE_W-1:0] PREAMBLE = 10'h2aa;
  localparam logic [CRC_W-1:0] CRC_INIT = 16'hffff;
  localparam logic [CRC_W-1:0] CRC_POLY = 16'h1021;

  // ************************************************************
  // register map and fields
  // ************************************************************
  localparam logic [7:0] REG_CONFIG  = 8'h00;
  localparam logic [7:0] REG_TX_ADDR = 8'h04;
  localparam logic [7:0] REG_TX_PAY  = 8'h08;
  localparam logic [7:0] REG_RX_ADDR = 8'h0c;
  localparam logic [7:0] REG_RX_PAY  = 8'h10;
  localparam logic [7:0] REG_STATUS  = 8'h14;
  localparam int CFG_RESEND_BIT = 0;
  localparam int ST_DR          = 0;
  localparam int ST_AM          = 1;
  localparam int ST_CD          = 2;
  localparam int ST_MODE_LSB    = 4;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // ************************************************************
  // synchroniser lanes
  // ************************************************************
  localparam int SYNC_W = 6;
  localparam int S_PU   = 0;
  localparam int S_CE   = 1;
  localparam int S_TXS  = 2;
  localparam int S_CAR  = 3;
  localparam int S_RCK  = 4;
  localparam int S_RDT  = 5;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0] {
    ST_PWRDN   = 3'h0,
    ST_STANDBY = 3'h1,
    ST_SETTLE  = 3'h3,
    ST_LISTEN  = 3'h2,
    ST_TAKE    = 3'h6,
    ST_SEND    = 3'h7,
    ST_HOLD    = 3'h5
  } mode_t;

  typedef enum logic [1:0] {
    SEL_PD = 2'h0,
    SEL_SB = 2'h1,
    SEL_RX = 2'h2,
    SEL_TX = 2'h3
  } sel_t;

  // crc over a 32-bit word, msb first
  function automatic logic [CRC_W-1:0] crc_word(input logic [CRC_W-1:0] c,
                                                input logic [31:0] w);
    logic [CRC_W-1:0] r;
    logic             fb;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      fb = r[CRC_W-1] ^ w[i];
      r  = {r[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
    end
    return r;
  endfunction

endpackage

// [design/burst_radio_mode_packet_control.sv]
// mode selection, packet send and packet receive control of a burst radio
`timescale 1ns/1ps
module burst_radio_mode_packet_control #(
  parameter int SETTLE_CYCLES = pkt_pkg::SETTLE_CYC
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        power_up_pin,
  input  wire logic        radio_enable_pin,
  input  wire logic        tx_select_pin,
  input  wire logic        carrier_in,
  input  wire logic        rx_clk_in,
  input  wire logic        rx_data_in,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             data_ready_out,
  output logic             addr_match_out,
  output logic             carrier_sense_out,
  output logic             radio_on_out,
  output logic             tx_data_out,
  output logic             carrier_only_out
);
  import pkt_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [SYNC_W-1:0]   sync1;
    logic [SYNC_W-1:0]   sync2;
    logic                rck_prev;
    mode_t               state;
    logic [SETTLE_W-1:0] settle;
    logic [DIV_W-1:0]    div;
    logic [IDX_W-1:0]    idx;
    logic [PKT_W-1:0]    tx_sr;
    logic [ADDR_W-1:0]   rx_win;
    logic [PAY_W+CRC_W-1:0] rx_sr;
    logic                auto_resend;
    logic [ADDR_W-1:0]   tx_addr;
    logic [PAY_W-1:0]    tx_pay;
    logic [ADDR_W-1:0]   rx_addr;
    logic [PAY_W-1:0]    rx_pay;
    logic                dr;
    logic                dr_tx;
    logic                am;
    logic                cd;
    logic                radio_on;
    logic                tx_bit;
    logic                hold;
    logic [31:0]         rdata;
  } ctl_t;

  ctl_t q;
  ctl_t d;

  logic             pu;
  logic             ce;
  logic             txs;
  logic             car;
  logic             rx_bit;
  logic             rx_edge;
  logic             bit_tick;
  sel_t             sel;
  sel_t             cls;
  logic             go;
  logic [31:0]      st_word;
  logic [PAY_W+CRC_W-1:0] nsr;
  logic [ADDR_W-1:0] nwin;

  // ************************************************************
  // pin decode
  // ************************************************************
  // only the second synchroniser stage is looked at
  assign pu       = q.sync2[S_PU];
  assign ce       = q.sync2[S_CE];
  assign txs      = q.sync2[S_TXS];
  assign car      = q.sync2[S_CAR];
  assign rx_bit   = q.sync2[S_RDT];
  assign rx_edge  = q.sync2[S_RCK] & ~q.rck_prev;
  assign bit_tick = (q.div == DIV_W'(BIT_CYC - 1));
  assign nsr      = {q.rx_sr[PAY_W+CRC_W-2:0], rx_bit};
  assign nwin     = {q.rx_win[ADDR_W-2:0], rx_bit};

  // selected mode from the pins
  always_comb begin
    if (!pu) begin
      sel = SEL_PD;
    end else if (!ce) begin
      sel = SEL_SB;
    end else if (txs) begin
      sel = SEL_TX;
    end else begin
      sel = SEL_RX;
    end
  end

  // class of the current state, to spot a pin change
  always_comb begin
    case (q.state)
      ST_PWRDN:   cls = SEL_PD;
      ST_STANDBY: cls = SEL_SB;
      ST_SETTLE,
      ST_LISTEN,
      ST_TAKE:    cls = SEL_RX;
      ST_SEND,
      ST_HOLD:    cls = SEL_TX;
      default:    cls = SEL_PD;
    endcase
  end

  // status word
  always_comb begin
    st_word                           = RST_WORD;
    st_word[ST_DR]                    = q.dr;
    st_word[ST_AM]                    = q.am;
    st_word[ST_CD]                    = q.cd;
    st_word[ST_MODE_LSB+2:ST_MODE_LSB] = q.state;
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    d       = q;
    go      = 1'b0;
    d.sync1 = {rx_data_in, rx_clk_in, carrier_in,
               tx_select_pin, radio_enable_pin, power_up_pin};
    d.sync2    = q.sync1;
    d.rck_prev = q.sync2[S_RCK];

    // register reads, data one cycle later
    d.rdata = RST_WORD;
    if (reg_rd) begin
      case (reg_addr)
        REG_CONFIG:  d.rdata[CFG_RESEND_BIT] = q.auto_resend;
        REG_TX_ADDR: d.rdata = q.tx_addr;
        REG_TX_PAY:  d.rdata = q.tx_pay;
        REG_RX_ADDR: d.rdata = q.rx_addr;
        REG_RX_PAY:  d.rdata = q.rx_pay;
        REG_STATUS:  d.rdata = st_word;
        default:     d.rdata = RST_WORD;
      endcase
    end

    // register writes; no mode touches them, power down included
    if (reg_wr) begin
      case (reg_addr)
        REG_CONFIG:  d.auto_resend = reg_wdata[CFG_RESEND_BIT];
        REG_TX_ADDR: d.tx_addr = reg_wdata;
        REG_TX_PAY:  d.tx_pay = reg_wdata;
        REG_RX_ADDR: d.rx_addr = reg_wdata;
        default:     d.tx_pay = q.tx_pay;
      endcase
    end

    // payload read out in one word, so one read empties it
    if (reg_rd && reg_addr == REG_RX_PAY && q.dr && !q.dr_tx) begin
      d.dr = 1'b0;
      d.am = 1'b0;
    end

    // transmit data ready falls with select or power-up
    if (q.dr && q.dr_tx && (!txs || !pu)) begin
      d.dr = 1'b0;
    end

    // clears above, sets below: a set in the same cycle wins
    case (q.state)
      ST_PWRDN,
      ST_STANDBY: begin
        go = (sel != cls);
      end
      ST_SETTLE: begin
        d.settle = q.settle + 1'b1;
        if (q.settle == SETTLE_W'(SETTLE_CYCLES - 1)) begin
          d.state  = ST_LISTEN;
          d.rx_win = '0;
        end
        go = (sel != cls);
      end
      ST_LISTEN: begin
        // a pending payload is kept; no hunting until it is read
        if (rx_edge && !q.dr) begin
          d.rx_win = nwin;
          if (car && nwin == q.rx_addr) begin
            d.am    = 1'b1;
            d.state = ST_TAKE;
            d.idx   = '0;
          end
        end
        go = (sel != cls);
      end
      ST_TAKE: begin
        if (rx_edge) begin
          d.rx_sr = nsr;
          d.idx   = q.idx + 1'b1;
          if (q.idx == IDX_W'(PAY_W + CRC_W - 1)) begin
            d.state  = ST_LISTEN;
            d.rx_win = '0;
            if (crc_word(crc_word(CRC_INIT, q.rx_addr), nsr[PAY_W+CRC_W-1:CRC_W])
                == nsr[CRC_W-1:0]) begin
              d.rx_pay = nsr[PAY_W+CRC_W-1:CRC_W];
              d.dr     = 1'b1;
              d.dr_tx  = 1'b0;
            end else begin
              d.am = 1'b0;
            end
          end
        end
        if (sel != cls) begin
          go   = 1'b1;
          d.am = 1'b0;
        end
      end
      ST_SEND: begin
        // pins are not looked at until the last bit is out
        d.div = bit_tick ? '0 : q.div + 1'b1;
        if (bit_tick) begin
          if (q.idx == IDX_W'(PKT_W - 1)) begin
            d.dr    = 1'b1;
            d.dr_tx = 1'b1;
            if (sel == SEL_TX && q.auto_resend) begin
              go = 1'b1;
            end else if (sel == SEL_TX) begin
              d.state = ST_HOLD;
            end else begin
              go = 1'b1;
            end
          end else begin
            d.idx    = q.idx + 1'b1;
            d.tx_sr  = q.tx_sr << 1;
            d.tx_bit = q.tx_sr[PKT_W-2];
          end
        end
      end
      ST_HOLD: begin
        go = (sel != cls);
      end
      default: begin
        go = 1'b1;
      end
    endcase

    // entry into the selected mode
    if (go) begin
      case (sel)
        SEL_PD: d.state = ST_PWRDN;
        SEL_SB: d.state = ST_STANDBY;
        SEL_RX: begin
          d.state  = ST_SETTLE;
          d.settle = '0;
        end
        SEL_TX: begin
          // packet is built from whatever the host left in the registers
          d.state  = ST_SEND;
          d.idx    = '0;
          d.div    = '0;
          d.tx_sr  = {PREAMBLE, q.tx_addr, q.tx_pay,
                      crc_word(crc_word(CRC_INIT, q.tx_addr), q.tx_pay)};
          d.tx_bit = PREAMBLE[PRE_W-1];
        end
        default: d.state = ST_PWRDN;
      endcase
    end

    // output flops follow the state being entered
    d.radio_on = (d.state == ST_SEND) || (d.state == ST_HOLD) ||
                 (d.state == ST_SETTLE) || (d.state == ST_LISTEN) ||
                 (d.state == ST_TAKE);
    d.hold     = (d.state == ST_HOLD);
    d.cd       = car && ((d.state == ST_LISTEN) || (d.state == ST_TAKE));
    if (d.state != ST_SEND) begin
      d.tx_bit = 1'b0;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  // configuration only ever resets with reset_n
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign reg_rdata         = q.rdata;
  assign data_ready_out    = q.dr;
  assign addr_match_out    = q.am;
  assign carrier_sense_out = q.cd;
  assign radio_on_out      = q.radio_on;
  assign tx_data_out       = q.tx_bit;
  assign carrier_only_out  = q.hold;

endmodule

// [test/brmpc_properties.sv]
// port-level assertion checker for the radio mode and packet control block
`timescale 1ns/1ps
module brmpc_checker #(
  parameter int SETTLE_CYCLES = 20
) (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        power_up_pin,
  input wire logic        radio_enable_pin,
  input wire logic        tx_select_pin,
  input wire logic        carrier_in,
  input wire logic        rx_clk_in,
  input wire logic        rx_data_in,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        data_ready_out,
  input wire logic        addr_match_out,
  input wire logic        carrier_sense_out,
  input wire logic        radio_on_out,
  input wire logic        tx_data_out,
  input wire logic        carrier_only_out
);
  import pkt_pkg::*;
  // ****************
  // port relations
  // ****************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // a bit on the air needs a powered radio
  a_tx_needs_radio: assert property (tx_data_out |-> radio_on_out)
    else $error("tx bit with radio off");
  a_hold_quiet: assert property (carrier_only_out |-> radio_on_out && !tx_data_out)
    else $error("carrier hold is modulated");
  a_cd_radio_on: assert property (carrier_sense_out |-> radio_on_out && !carrier_only_out)
    else $error("carrier sense outside receive");
  a_cd_follows_in: assert property (carrier_sense_out |->
    $past(carrier_in, 2) || $past(carrier_in, 3) || $past(carrier_in, 4))
    else $error("carrier sense without carrier");
  a_am_with_carrier: assert property ($rose(addr_match_out) |-> carrier_sense_out)
    else $error("address match without carrier");
  a_rdata_one_cycle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");
  a_rx_read_clears: assert property (reg_rd && reg_addr == REG_RX_PAY && data_ready_out
    && addr_match_out |=> !data_ready_out && !addr_match_out)
    else $error("payload read left flags up");
  // sync plus state latency is three edges, five gives margin
  a_pd_no_carrier: assert property ((!power_up_pin)[*5] |-> !carrier_sense_out)
    else $error("carrier sense in power down");
  c_rx_done: cover property ($rose(data_ready_out));
  c_am_drop: cover property ($fell(addr_match_out));
  c_tx_bit: cover property ($rose(tx_data_out));
endmodule
bind burst_radio_mode_packet_control brmpc_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_chk (
  .mclk(mclk), .reset_n(reset_n), .power_up_pin(power_up_pin),
  .radio_enable_pin(radio_enable_pin), .tx_select_pin(tx_select_pin),
  .carrier_in(carrier_in), .rx_clk_in(rx_clk_in), .rx_data_in(rx_data_in),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .data_ready_out(data_ready_out), .addr_match_out(addr_match_out),
  .carrier_sense_out(carrier_sense_out), .radio_on_out(radio_on_out),
  .tx_data_out(tx_data_out), .carrier_only_out(carrier_only_out));

// [test/rf_front_model.sv]
// behavioural radio front end that delivers received frames
`timescale 1ns/1ps
module rf_front_model (
  output logic carrier_in,
  output logic rx_clk_in,
  output logic rx_data_in
);
  import pkt_pkg::*;
  // idle: bit clock stands still, no carrier
  initial begin
    carrier_in = 1'b0;
    rx_clk_in  = 1'b0;
    rx_data_in = 1'b0;
  end
  // crc over address then payload, msb first
  function automatic logic [15:0] crc(input logic [63:0] d);
    logic [15:0] r;
    r = CRC_INIT;
    for (int i = 63; i >= 0; i--) begin
      r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? CRC_POLY : 16'h0000);
    end
    return r;
  endfunction
  // only the first nb bits go out, so a frame can be cut short
  task automatic send(input logic [31:0] a, input logic [31:0] p, input logic bad,
                      input int nb);
    logic [89:0] f;
    f = {PREAMBLE, a, p, crc({a, p}) ^ {15'h0000, bad}};
    carrier_in = 1'b1;
    for (int i = 89; i >= 90 - nb; i--) begin
      rx_data_in = f[i];
      #40;
      rx_clk_in = 1'b1;
      #40;
      rx_clk_in = 1'b0;
    end
    carrier_in = 1'b0;
    rx_data_in = ~rx_data_in; // released line shows no stale value
  endtask
endmodule

// [test/tb_top.sv]
// self-checking bench for the radio mode and packet control block
`timescale 1ns/1ps
module tb_top;
  import pkt_pkg::*;
  logic        mclk, reset_n, pu, ce, txs, car, rck, rdt, reg_wr, reg_rd;
  logic        dr, am, cd, ron, txd, cwo;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  int          mismatches, total_checks;
  localparam logic [31:0] RXA = 32'hc3a5_5a3c;
  localparam logic [31:0] PAY = 32'h1234_5678;
  burst_radio_mode_packet_control #(.SETTLE_CYCLES(20)) i_dut (
    .mclk(mclk), .reset_n(reset_n), .power_up_pin(pu), .radio_enable_pin(ce),
    .tx_select_pin(txs), .carrier_in(car), .rx_clk_in(rck), .rx_data_in(rdt),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .data_ready_out(dr), .addr_match_out(am),
    .carrier_sense_out(cd), .radio_on_out(ron), .tx_data_out(txd), .carrier_only_out(cwo));
  rf_front_model i_rf (.carrier_in(car), .rx_clk_in(rck), .rx_data_in(rdt));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] st(input mode_t m);
    return {25'h000_0000, m, 4'h0};
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // data stands only in the cycle after the read edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // six edges covers the two sync flops and the state update
  task automatic pins(input logic p, input logic c, input logic t);
    @(posedge mclk);
    pu <= p;
    ce <= c;
    txs <= t;
    repeat (6) @(posedge mclk);
  endtask
  // bounded wait on data ready (s=0) or the tx bit (s=1)
  task automatic wait_sig(input bit s, input logic val, input int lim);
    int n;
    n = 0;
    while (((s ? txd : dr) !== val) && n < lim) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n == lim) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, s ? txd : dr, val);
      results();
    end
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    {pu, ce, txs, reg_wr, reg_rd} = 5'h00;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reset_n = 1'b0;
    mismatches = 0;
    total_checks = 0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    pins(1'b0, 1'b1, 1'b1);
    rd(REG_STATUS, v); chk(v, st(ST_PWRDN));
    wr(REG_CONFIG, 32'h0000_0001);
    wr(REG_RX_ADDR, RXA);
    wr(REG_TX_ADDR, 32'h0f1e_2d3c);
    wr(REG_TX_PAY, PAY);
    wr(REG_STATUS, 32'h0000_00ff);
    $display("test power down done");
    pins(1'b1, 1'b0, 1'b1);
    rd(REG_STATUS, v); chk(v, st(ST_STANDBY));
    rd(REG_CONFIG, v); chk(v, 32'h0000_0001);
    rd(REG_RX_ADDR, v); chk(v, RXA);
    rd(8'h18, v); chk(v, 32'h0000_0000);
    $display("test standby done");
    pins(1'b1, 1'b1, 1'b0);
    rd(REG_STATUS, v); chk(v, st(ST_SETTLE));
    repeat (30) @(posedge mclk);
    rd(REG_STATUS, v); chk(v, st(ST_LISTEN));
    fork
      i_rf.send(RXA, PAY, 1'b0, 90);
      begin
        repeat (100) @(posedge mclk);
        chk(cd, 1'b1);
      end
    join
    wait_sig(1'b0, 1'b1, 50);
    chk(am, 1'b1);
    rd(REG_STATUS, v); chk(v & 32'h0000_0003, 32'h0000_0003);
    rd(REG_RX_PAY, v); chk(v, PAY);
    chk({dr, am}, 2'h0);
    $display("test good frame done");
    i_rf.send(RXA, 32'h5555_aaaa, 1'b1, 90);
    repeat (20) @(posedge mclk);
    chk({dr, am}, 2'h0);
    rd(REG_RX_PAY, v); chk(v, PAY);
    i_rf.send(RXA, PAY, 1'b0, 60);
    repeat (8) @(posedge mclk);
    chk(am, 1'b1);
    pins(1'b1, 1'b0, 1'b0);
    chk({dr, am}, 2'h0);
    rd(REG_STATUS, v); chk(v, st(ST_STANDBY));
    $display("test bad and cut frames done");
    pins(1'b1, 1'b1, 1'b0);
    repeat (30) @(posedge mclk);
    pins(1'b1, 1'b1, 1'b1);
    rd(REG_STATUS, v); chk(v, st(ST_SEND));
    chk(ron, 1'b1);
    // preamble alternates, so the first fall marks a bit boundary
    wait_sig(1'b1, 1'b0, 2100);
    repeat (1995) @(posedge mclk);
    #1 chk(txd, 1'b0);
    repeat (10) @(posedge mclk);
    #1 chk(txd, 1'b1);
    pins(1'b1, 1'b0, 1'b1);
    rd(REG_STATUS, v); chk(v, st(ST_SEND));
    pins(1'b0, 1'b0, 1'b0);
    rd(REG_STATUS, v); chk(v, st(ST_SEND));
    $display("test transmit done");
    results();
  end
endmodule
